// file: include/wdg_regs.svh
// Purpose: register indices, bit positions, reset values and counts
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_STAT_IDX 8'h55
`define WDG_CTRL_IDX 8'h60

`define WDG_STAT_DOG 3
`define WDG_STAT_BROWN 2
`define WDG_STAT_PIN 1
`define WDG_STAT_POWER 0
`define WDG_STAT_POR_VAL 4'h1

`define WDG_CTRL_IRQ_FLAG 7
`define WDG_CTRL_IRQ_EN 6
`define WDG_CTRL_SEL_HI 5
`define WDG_CTRL_UNLOCK 4
`define WDG_CTRL_RST_EN 3
`define WDG_CTRL_RST_VAL 8'h00

`define WDG_UNLOCK_CYCLES 3'h4
`define WDG_BASE_CYCLES 2048
`define WDG_SEL_MAX 4'h9

`endif

// file: include/wdg_pkg.sv
// Purpose: types shared by the watchdog and reset-flag block
// Assumes: nothing
// Notes: struct layouts follow the register bit order
package wdg_pkg;

  typedef enum logic [1:0] {
    WDG_STOP,
    WDG_IRQ,
    WDG_RST,
    WDG_BOTH
  } wdg_mode_t;

  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic sel_hi;
    logic unlock;
    logic rst_en;
    logic [2:0] sel_lo;
  } wdg_ctrl_t;

  typedef struct packed {
    logic dog;
    logic brown;
    logic pin;
    logic power;
  } wdg_flags_t;

endpackage

// file: hw/wdg_sync.sv
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: inputs are levels
// Notes: first stage feeds only the second stage
module wdg_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = ce_i ? d_i : meta_r;
    sync_nxt = ce_i ? meta_r : sync_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_o = sync_r;
endmodule // wdg_sync

// file: hw/wdg_counter.sv
// Purpose: counts oscillator edges and flags a time-out
// Assumes: osc_i is already synchronised to clk_i
// Notes: timeout_o is a one-cycle pulse from a flop
`include "wdg_regs.svh"
module wdg_counter #(
  parameter int BASE_COUNT = `WDG_BASE_CYCLES,
  parameter int CW = 21
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic osc_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [3:0] sel_i,
  output logic timeout_o
);
  logic osc_q_r;
  logic osc_q_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tout_r;
  logic tout_nxt;
  logic [3:0] sel_eff;
  logic [CW-1:0] lim;
  logic rise;

  always_comb
  begin
    sel_eff = (sel_i > `WDG_SEL_MAX) ? `WDG_SEL_MAX : sel_i; // R23
    lim = CW'(BASE_COUNT) << sel_eff; // R17
    rise = osc_i & ~osc_q_r; // R19
    osc_q_nxt = osc_i;
    cnt_nxt = cnt_r;
    tout_nxt = 1'b0;
    if (!run_i || restart_i)
      cnt_nxt = '0; // R21
    else if (rise)
    begin
      if (cnt_r >= lim - CW'(1))
      begin
        cnt_nxt = '0;
        tout_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_q_r <= 1'b0;
      cnt_r <= '0;
      tout_r <= 1'b0;
    end
    else if (ce_i)
    begin
      osc_q_r <= osc_q_nxt;
      cnt_r <= cnt_nxt;
      tout_r <= tout_nxt;
    end
  end

  assign timeout_o = tout_r;
endmodule // wdg_counter

// file: hw/wdg_top.sv
// Purpose: watchdog control and reset-source flags on classic Wishbone
// Assumes: osc_i, bor_rst_i, pin_rst_i, always_on_fuse_n_i are asynchronous
// Notes: rst_i acts as the power-on reset of the block
//
// Function
// R1 - upper four bits of reset-source status always read zero
// R2 - watchdog reset sets its flag; power-on or written zero clears
// R3 - brown-out reset sets its flag; power-on or written zero clears
// R4 - pin reset sets its flag; power-on or written zero clears
// R5 - power-on sets its flag; only a written zero clears it
// R6 - time-out in interrupt operation sets the interrupt flag, bit 7
// R7 - vector execution or a written one clears the interrupt flag
// R8 - interrupt taken only while global enable and bit 6 both set
// R9 - enables select stopped, interrupt, reset, or interrupt-then-reset
// R10 - programmed always-on fuse forces reset mode on every time-out
// R11 - combined mode: vector clears interrupt enable and flag
// R12 - combined mode: time-out with flag still pending resets system
// R13 - software re-enables interrupt after each one, outside the handler
// R14 - change-unlock bit 4 self-clears four clocks after written one
// R15 - reset-enable clear and period change need unlock set
// R16 - watchdog reset flag forces reset-enable to one
// R17 - period select bit 5 and 2..0; 2048 doubling to 1048576
// R18 - software reads then clears reset flags early after start-up
// R19 - counter advances on edges of a separate 128 kHz oscillator
// R20 - software unlocks, then writes settings within four clocks
// R21 - restart command clears the counter to zero
// R22 - watchdog system reset is a one-clock pulse
// R23 - reserved period codes act as the longest period
// R24 - oscillator and reset inputs are synchronised before use
`include "wdg_regs.svh"
module wdg_top #(
  parameter int BASE_COUNT = `WDG_BASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_i,
  input wire logic bor_rst_i,
  input wire logic pin_rst_i,
  input wire logic always_on_fuse_n_i,
  input wire logic restart_i,
  input wire logic gie_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  output logic sys_rst_o,
  output wdg_pkg::wdg_mode_t mode_o
);
  import wdg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  logic [3:0] sync_q;
  logic osc_s;
  logic bor_s;
  logic pin_s;
  logic fuse_s;

  wdg_sync #(
    .W(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({osc_i, bor_rst_i, pin_rst_i, always_on_fuse_n_i}),
    .q_o(sync_q)
  );

  always_comb
  begin
    osc_s = sync_q[3]; // R24
    bor_s = sync_q[2]; // R24
    pin_s = sync_q[1]; // R24
    fuse_s = sync_q[0]; // R24
  end

  ////////////////////////////////////////////////////////////////////////
  // state declarations

  wdg_flags_t flags_r;
  wdg_flags_t flags_nxt;
  wdg_ctrl_t ctrl_r;
  wdg_ctrl_t ctrl_nxt;
  logic [2:0] unl_cnt_r;
  logic [2:0] unl_cnt_nxt;
  logic fire_r;
  logic fire_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;

  logic wde_eff;
  logic timeout_irq_enable_eff;
  logic sys_evt;
  logic timeout;
  logic req;
  logic wr_stat;
  logic wr_ctrl;
  logic [7:0] wdat;
  logic [7:0] ctrl_rd;
  wdg_mode_t mode;

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  always_comb
  begin
    wde_eff = ctrl_r.rst_en | flags_r.dog | ~fuse_s; // R16
    timeout_irq_enable_eff = ctrl_r.irq_en & fuse_s;
    if (!fuse_s)
      mode = WDG_RST; // R10
    else
    begin
      case ({wde_eff, timeout_irq_enable_eff}) // R9
        2'b01: mode = WDG_IRQ;
        2'b10: mode = WDG_RST;
        2'b11: mode = WDG_BOTH;
        default: mode = WDG_STOP;
      endcase
    end
  end

  assign mode_o = mode;

  ////////////////////////////////////////////////////////////////////////
  // time-out counter

  assign sys_evt = fire_r | bor_s | pin_s;

  wdg_counter #(
    .BASE_COUNT(BASE_COUNT),
    .CW(21)
  ) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .osc_i(osc_s),
    .run_i(mode != WDG_STOP),
    .restart_i(restart_i | sys_evt),
    .sel_i({ctrl_r.sel_hi, ctrl_r.sel_lo}),
    .timeout_o(timeout)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  always_comb
  begin
    req = wb_cyc_i & wb_stb_i & ~ack_r;
    wdat = wb_dat_i[7:0];
    wr_stat = req & wb_we_i & wb_sel_i[0]
      & (wb_adr_i[9:2] == `WDG_STAT_IDX);
    wr_ctrl = req & wb_we_i & wb_sel_i[0]
      & (wb_adr_i[9:2] == `WDG_CTRL_IDX);
    ctrl_rd = {ctrl_r.irq_flag, timeout_irq_enable_eff, ctrl_r.sel_hi, ctrl_r.unlock,
      wde_eff, ctrl_r.sel_lo};
  end

  always_comb
  begin
    ack_nxt = req;
    dat_nxt = dat_r;
    if (req)
    begin
      if (wb_adr_i[9:2] == `WDG_STAT_IDX)
        dat_nxt = {28'h0000000, flags_r}; // R1
      else if (wb_adr_i[9:2] == `WDG_CTRL_IDX)
        dat_nxt = {24'h000000, ctrl_rd};
      else
        dat_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else if (ce_i)
    begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////
  // reset-source flags

  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_stat)
      flags_nxt = flags_r & wdg_flags_t'(wdat[3:0]); // R5
    if (fire_r)
      flags_nxt.dog = 1'b1; // R2
    if (bor_s)
      flags_nxt.brown = 1'b1; // R3
    if (pin_s)
      flags_nxt.pin = 1'b1; // R4
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_r <= wdg_flags_t'(`WDG_STAT_POR_VAL); // R2 R3 R4 R5
    else if (ce_i)
      flags_r <= flags_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and time-out actions

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    unl_cnt_nxt = unl_cnt_r;
    fire_nxt = 1'b0;
    if (ctrl_r.unlock)
    begin
      if (unl_cnt_r == 3'h1)
        ctrl_nxt.unlock = 1'b0; // R14
      unl_cnt_nxt = unl_cnt_r - 3'h1;
    end
    if (wr_ctrl)
    begin
      ctrl_nxt.irq_en = wdat[`WDG_CTRL_IRQ_EN];
      if (wdat[`WDG_CTRL_IRQ_FLAG])
        ctrl_nxt.irq_flag = 1'b0; // R7
      if (ctrl_r.unlock)
      begin
        ctrl_nxt.rst_en = wdat[`WDG_CTRL_RST_EN]; // R15
        ctrl_nxt.sel_hi = wdat[`WDG_CTRL_SEL_HI]; // R15
        ctrl_nxt.sel_lo = wdat[2:0]; // R15
      end
      else
        ctrl_nxt.rst_en = ctrl_r.rst_en | wdat[`WDG_CTRL_RST_EN]; // R15
      ctrl_nxt.unlock = wdat[`WDG_CTRL_UNLOCK];
      if (wdat[`WDG_CTRL_UNLOCK])
        unl_cnt_nxt = `WDG_UNLOCK_CYCLES; // R14
    end
    if (irq_ack_i && ctrl_r.irq_flag)
    begin
      ctrl_nxt.irq_flag = 1'b0; // R7
      if (wde_eff)
        ctrl_nxt.irq_en = 1'b0; // R11
    end
    if (timeout)
    begin
      case (mode)
        WDG_IRQ: ctrl_nxt.irq_flag = 1'b1; // R6
        WDG_RST: fire_nxt = 1'b1; // R10
        WDG_BOTH:
        begin
          if (ctrl_r.irq_flag)
            fire_nxt = 1'b1; // R12
          else
            ctrl_nxt.irq_flag = 1'b1; // R11
        end
        default: fire_nxt = 1'b0;
      endcase
    end
    if (sys_evt)
    begin
      ctrl_nxt = wdg_ctrl_t'(`WDG_CTRL_RST_VAL);
      unl_cnt_nxt = 3'h0;
    end
    if (flags_nxt.dog)
      ctrl_nxt.rst_en = 1'b1; // R16
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= wdg_ctrl_t'(`WDG_CTRL_RST_VAL);
      unl_cnt_r <= 3'h0;
      fire_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ctrl_r <= ctrl_nxt;
      unl_cnt_r <= unl_cnt_nxt;
      fire_r <= fire_nxt; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign sys_rst_o = fire_r & ce_i; // R22
  assign irq_o = ctrl_r.irq_flag & timeout_irq_enable_eff & gie_i; // R8
endmodule // wdg_top

// file: test/wdg_top_monitor.sv
// Purpose: port checks for wdg_top
// Assumes: ce_i held high
// Notes: bound at the foot of this file
module wdg_top_monitor #(
  parameter int BASE_COUNT = 2048
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic always_on_fuse_n_i,
  input wire logic gie_i,
  input wire logic irq_ack_i,
  input wire logic irq_o,
  input wire logic sys_rst_o,
  input wire wdg_pkg::wdg_mode_t mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import wdg_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_stat;
    wb_ack_o && !wb_we_i && wb_adr_i == 10'h154 |-> !(|wb_dat_o[31:4]);
  endproperty
  a_stat: assert property (p_stat) else $error("high bits");
  property p_pulse;
    sys_rst_o |=> !sys_rst_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long reset");
  property p_gate;
    irq_o |-> gie_i && mode_o[0];
  endproperty
  a_gate: assert property (p_gate) else $error("irq gate");
  property p_fuse;
    !always_on_fuse_n_i [*4] |-> mode_o == WDG_RST;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse mode");
  property p_vec;
    irq_ack_i && irq_o && mode_o == WDG_BOTH |=> mode_o == WDG_RST;
  endproperty
  a_vec: assert property (p_vec) else $error("vector mode");
  property p_clr;
    irq_ack_i && irq_o |=> !irq_o;
  endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_cause;
    sys_rst_o |-> $past(mode_o[1]);
  endproperty
  a_cause: assert property (p_cause) else $error("bad reset");
  c_wr: cover property (wb_ack_o && wb_we_i);
  c_rst: cover property (sys_rst_o);
  c_vec: cover property (irq_o && irq_ack_i);
endmodule // wdg_top_monitor

bind wdg_top wdg_top_monitor #(.BASE_COUNT(BASE_COUNT)) u_mon (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .always_on_fuse_n_i(always_on_fuse_n_i),
  .gie_i(gie_i),
  .irq_ack_i(irq_ack_i),
  .irq_o(irq_o),
  .sys_rst_o(sys_rst_o),
  .mode_o(mode_o)
);

// file: test/wdg_top_tb_top.sv
// Purpose: directed bench for wdg_top
// Assumes: BASE_COUNT 4, osc period 320 ns
// Notes: bus tasks follow classic Wishbone
module wdg_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdg_pkg::*;
  localparam logic [9:0] ST = 10'h154;
  localparam logic [9:0] CT = 10'h180;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, osc_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic bor_rst_i = 1'b0, pin_rst_i = 1'b0, always_on_fuse_n_i = 1'b1;
  logic restart_i = 1'b0, gie_i = 1'b0, irq_ack_i = 1'b0;
  logic wb_ack_o, irq_o, sys_rst_o;
  wdg_mode_t mode_o;
  logic [7:0] q;
  int mismatches = 0, check_count = 0, n, s;
  wdg_top #(.BASE_COUNT(4)) DUT (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .osc_i, .bor_rst_i, .pin_rst_i, .always_on_fuse_n_i,
    .restart_i, .gie_i, .irq_ack_i, .irq_o, .sys_rst_o, .mode_o);
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    #7;
    forever #160 osc_i = ~osc_i;
  end
  ////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    end_of_test();
  endtask
  task automatic chk(input string t, input logic [7:0] e, g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", t, e, g);
    end
  endtask
  task automatic bus(input logic [9:0] a, input logic w, logic [7:0] d);
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
      tmo();
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic kick();
    restart_i <= 1'b1;
    @(posedge clk_i);
    restart_i <= 1'b0;
  endtask
  task automatic go(input logic r);
    kick();
    n = 0;
    while ((r ? sys_rst_o : irq_o) !== 1'b1 && n < 25000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 25000)
      tmo();
  endtask
  task automatic vec();
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    @(posedge clk_i);
  endtask
  ////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(ST, 8'h01);
    rc(CT, 8'h00);
    wr(10'h0, 8'hff);
    rc(10'h0, 8'h00);
    wr(ST, 8'hfe);
    rc(ST, 8'h00);
    pin_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin_rst_i <= 1'b0;
    bor_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    bor_rst_i <= 1'b0;
    rc(ST, 8'h06);
    wr(ST, 8'hfd);
    rc(ST, 8'h04);
    wr(ST, 8'hf0);
    rc(ST, 8'h00);
    $display("done flags");
    gie_i <= 1'b1;
    wr(CT, 8'h40);
    go(1'b0);
    rc(CT, 8'hc0);
    vec();
    rc(CT, 8'h40);
    go(1'b0);
    wr(CT, 8'hc0);
    rc(CT, 8'h40);
    wr(CT, 8'h80);
    $display("done irq");
    wr(CT, 8'h0f);
    rc(CT, 8'h08);
    wr(CT, 8'h00);
    rc(CT, 8'h08);
    wr(CT, 8'h18);
    rc(CT, 8'h18);
    rc(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h21);
    rc(CT, 8'h21);
    $display("done unlock");
    for (s = 0; s < 2; s++)
    begin
      wr(CT, 8'h18);
      wr(CT, 8'h08 | 8'(s));
      go(1'b1);
      chk("period", 8'h1, 8'(n > (24 << s) && n < (40 << s)));
    end
    wr(CT, 8'h18);
    wr(CT, 8'h2a);
    go(1'b1);
    chk("reserved", 8'h1, 8'(n > (24 << 9) && n < (40 << 9)));
    kick();
    rc(ST, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rc(CT, 8'h08);
    kick();
    wr(ST, 8'h00);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rc(CT, 8'h00);
    $display("done reset");
    wr(CT, 8'h48);
    go(1'b0);
    vec();
    chk("mode", {6'h0, WDG_RST}, {6'h0, mode_o});
    rc(CT, 8'h08);
    wr(CT, 8'h48);
    go(1'b0);
    go(1'b1);
    rc(ST, 8'h08);
    wr(ST, 8'h00);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    always_on_fuse_n_i <= 1'b0;
    wr(CT, 8'h40);
    rc(CT, 8'h08);
    go(1'b1);
    $display("done modes");
    end_of_test();
  end
endmodule // wdg_top_tb_top
